// >>> rtl/atm_task_mode_ctrl.sv
// task and mode controller: modes, command decode, burst timing
// assumes the host drives the serial port and the slot pulse pin
// Function
// - activation moves device into deep sleep
// - leave-sleep task switches sleep to normal
// - sleep return goes via config mode
// - config mode keeps modulation off
// - tasks only valid in their mode
// - enter-config and exit-config switch modes
// - command register at C8 holds two fields
// - one write updates all fields
// - data task finishes before modem task
// - slot pulse echoed on output pin
// - delays counted in 24kHz ticks
// - burst events at configured tick delays
// - aux converter runs, tagged result at C9
// - dac task updates any converter combination
// - first converter may ramp during burst
// - interrupt when status and mask bit15
// - deep sleep stops all processing except the register port, task decode, interrupt and converter select outputs
// - modulation levels set in 0.2dB steps
// - deep sleep sets second_status_word bit13
module atm_task_mode_ctrl
	import atm_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYCLES
) (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             ser_sel_n_i,
	input  wire logic             ser_clk_i,
	input  wire logic             ser_din_i,
	input  wire logic             activation_done_i,
	input  wire logic             slot_timing_pulse_i,
	input  wire logic [9:0]       aux_converter_in_i,
	input  wire logic             aux_adc_valid_i,
	output logic                  ser_dout_o,
	output logic                  ser_dout_oe_o,
	output logic                  slot_pulse_echo_o,
	output logic                  interrupt_out_n_o,
	output logic                  interrupt_out_n_oe_o,
	output logic                  mod_active_o,
	output logic [7:0]            mod_level_a_o,
	output logic [7:0]            mod_level_b_o,
	output logic                  tx_enable_o,
	output logic                  carrier_sense_slot_check_o,
	output logic                  aux_adc_sel_o,
	output logic [3:0][9:0]       aux_dac_o,
	output logic                  deep_sleep_o
);
	// --------------------------------------------------------------
	// register port
	// --------------------------------------------------------------
	logic        wr_stb;
	logic        rd_stb;
	logic [7:0]  addr;
	logic [15:0] wr_data;
	logic [15:0] rd_data_w;

	atm_serial_port u_port (
		.ref_clk_i     (ref_clk_i),
		.rst_n_i       (rst_n_i),
		.ser_sel_n_i   (ser_sel_n_i),
		.ser_clk_i     (ser_clk_i),
		.ser_din_i     (ser_din_i),
		.rd_data_i     (rd_data_w),
		.ser_dout_o    (ser_dout_o),
		.ser_dout_oe_o (ser_dout_oe_o),
		.wr_stb_o      (wr_stb),
		.rd_stb_o      (rd_stb),
		.addr_o        (addr),
		.wr_data_o     (wr_data)
	);

	atm_mode_e        mode_reg;
	atm_mode_e        mode_next;
	logic [15:0]      host_mode_reg;
	logic [15:0]      mask_reg;
	logic [15:0]      status_reg;
	logic [15:0]      adc_result_reg;
	logic [3:0][15:0] wd_reg;
	logic [3:0]       data_code_reg;
	logic [3:0]       modem_code_reg;
	logic             data_pend_reg;
	logic             modem_pend_reg;
	logic             sleep_flag_reg;
	logic [2:0]       slot_s_reg;

	wire wr_mode = wr_stb && addr == ADDR_MODE;
	wire wr_mask = wr_stb && addr == ADDR_MASK;
	wire wr_cmd  = wr_stb && addr == ADDR_CMD;
	wire rd_stat = rd_stb && addr == ADDR_STATUS;
	wire [3:0] wr_wd = {4{wr_stb}} & {addr == ADDR_WD3,
		addr == ADDR_WD2, addr == ADDR_WD1, addr == ADDR_WD0};

	wire [15:0] second_status_word_w = {2'b00, sleep_flag_reg, 11'h000, mode_reg};
	assign rd_data_w = (addr == ADDR_STATUS)  ? status_reg :
	                   (addr == ADDR_SECOND_STATUS_WORD) ? second_status_word_w :
	                   (addr == ADDR_ADC)     ? adc_result_reg : 16'h0000;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_mode_reg <= RST_WORD;
			mask_reg      <= RST_WORD;
			wd_reg        <= '0;
		end else begin
			if (wr_mode)
				host_mode_reg <= wr_data;
			if (wr_mask)
				mask_reg <= wr_data;
			for (int i = 0; i < 4; i++)
				if (wr_wd[i])
					wd_reg[i] <= wr_data;
		end
	end

	// --------------------------------------------------------------
	// command decode and mode machine
	// --------------------------------------------------------------
	wire awake     = mode_reg == MODE_NORMAL || mode_reg == MODE_CONFIG;
	wire data_go   = data_pend_reg;
	wire modem_go  = modem_pend_reg && !data_pend_reg;
	wire in_norm   = mode_reg == MODE_NORMAL;
	wire in_cfg    = mode_reg == MODE_CONFIG;
	wire cfg_go    = modem_go && in_cfg;
	wire cfg_seq   = cfg_go && modem_code_reg == CT_TX_SEQUENCE;
	wire cfg_lvl   = cfg_go && modem_code_reg == CT_MOD_LEVEL;
	wire cfg_ramp  = cfg_go && modem_code_reg == CT_RAMP_VALUES;
	wire burst_go  = modem_go && in_norm &&
		(modem_code_reg == MT_TX_BURST ||
		 modem_code_reg == MT_TX_DATA_BURST);
	wire dac_go    = data_go && awake && data_code_reg == DT_DAC_WRITE;
	// only valid config tasks report done
	wire cfg_done  = cfg_seq || cfg_lvl || cfg_ramp ||
		(cfg_go && (modem_code_reg == CT_EXIT_CFG ||
		 modem_code_reg == CT_ENTER_SLEEP));

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			MODE_WAIT_ACT: begin
				if (activation_done_i)
					mode_next = MODE_SLEEP;
			end
			MODE_SLEEP: begin
				if (modem_go && modem_code_reg == CT_LEAVE_SLEEP)
					mode_next = MODE_NORMAL;
			end
			MODE_CONFIG: begin
				// exit config / sleep only from config
				if (modem_go && modem_code_reg == CT_EXIT_CFG)
					mode_next = MODE_NORMAL;
				else if (modem_go && modem_code_reg == CT_ENTER_SLEEP)
					mode_next = MODE_SLEEP;
			end
			MODE_NORMAL: begin
				if (modem_go && modem_code_reg == MT_ENTER_CFG)
					mode_next = MODE_CONFIG;
			end
			default: mode_next = MODE_WAIT_ACT;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_reg       <= MODE_WAIT_ACT;
			data_code_reg  <= 4'h0;
			modem_code_reg <= 4'h0;
			data_pend_reg  <= 1'b0;
			modem_pend_reg <= 1'b0;
			sleep_flag_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			sleep_flag_reg <= mode_next == MODE_SLEEP;
			if (data_go)
				data_pend_reg <= 1'b0;
			if (modem_go)
				modem_pend_reg <= 1'b0;
			// both fields taken from one write
			if (wr_cmd && mode_reg != MODE_WAIT_ACT) begin
				data_code_reg  <= wr_data[CMD_DATA_LSB +: 4];
				modem_code_reg <= wr_data[CMD_MODEM_LSB +: 4];
				data_pend_reg  <= wr_data[CMD_DATA_LSB +: 4] != 4'h0;
				modem_pend_reg <= wr_data[CMD_MODEM_LSB +: 4] != 4'h0;
			end
		end
	end

	// --------------------------------------------------------------
	// status, interrupt, aux converter input
	// --------------------------------------------------------------
	wire tx_done_w;
	wire [15:0] ev_set = 16'h0000 |
		(16'(cfg_done) << ST_CFG_DONE_BIT) |
		(16'(data_go && awake) << ST_DATA_DONE_BIT) |
		(16'(tx_done_w) << ST_TX_DONE_BIT);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_reg           <= RST_WORD;
			interrupt_out_n_oe_o <= 1'b0;
			adc_result_reg       <= RST_WORD;
			aux_adc_sel_o        <= 1'b0;
			slot_pulse_echo_o    <= 1'b0;
			deep_sleep_o         <= 1'b0;
		end else begin
			// read clears bits 15:1, not the activation bit; a new event wins
			if (rd_stat)
				status_reg[ST_IRQ_BIT:ST_CFG_DONE_BIT] <= ev_set[15:1];
			else
				status_reg <= status_reg | ev_set;
			if (ev_set != 16'h0000)
				status_reg[ST_IRQ_BIT] <= 1'b1;
			if (mode_reg == MODE_WAIT_ACT && activation_done_i)
				status_reg[ST_ACT_BIT] <= 1'b1;
			interrupt_out_n_oe_o <= status_reg[ST_IRQ_BIT] &
				mask_reg[MASK_IRQ_BIT];
			aux_adc_sel_o <= host_mode_reg[MODE_ADC_SEL_BIT];
			if (aux_adc_valid_i && awake)
				adc_result_reg <= 16'(aux_converter_in_i) |
					(16'(aux_adc_sel_o) << ADC_SEL_BIT);
			deep_sleep_o <= mode_reg == MODE_SLEEP;
			// echo of the synchronised slot pulse
			slot_pulse_echo_o <= slot_s_reg[1] & awake;
		end
	end
	// open collector: only ever pulls low
	assign interrupt_out_n_o = 1'b0;

	// --------------------------------------------------------------
	// slot timebase
	// --------------------------------------------------------------
	logic [13:0] pre_reg;
	logic [8:0]  tick_reg;
	logic        tick_stb_reg;
	wire slot_edge = slot_s_reg[1] & ~slot_s_reg[2] & awake;
	wire pre_wrap  = pre_reg == 14'(TICK_CYC - 1);

	// ticks restart at the slot edge; halted asleep
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slot_s_reg   <= 3'h0;
			pre_reg      <= 14'h0000;
			tick_reg     <= 9'h000;
			tick_stb_reg <= 1'b0;
		end else begin
			slot_s_reg   <= {slot_s_reg[1:0], slot_timing_pulse_i};
			tick_stb_reg <= slot_edge | (awake & pre_wrap);
			if (slot_edge || !awake || pre_wrap)
				pre_reg <= 14'h0000;
			else
				pre_reg <= pre_reg + 14'h0001;
			if (slot_edge || !awake)
				tick_reg <= 9'h000;
			else if (pre_wrap && tick_reg != SEQ_END_TICK)
				tick_reg <= tick_reg + 9'h001;
		end
	end

	// --------------------------------------------------------------
	// burst sequencer
	// --------------------------------------------------------------
	logic [7:0][7:0] dly_reg;
	logic [3:0][9:0] ramp_val_reg;
	logic [3:0][9:0] dac_reg;
	logic            arm_reg;
	logic            seq_reg;
	atm_ramp_e       ramp_reg;
	logic [1:0]      ramp_idx_reg;
	logic [7:0]      ramp_div_reg;
	logic [6:0]      hit;

	function automatic logic at_tick(input logic [8:0] t,
		input logic [7:0] d, input logic s, input logic en);
		at_tick = en && s && t == {1'b0, d};
	endfunction : at_tick

	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : g_hit
			assign hit[g] = at_tick(tick_reg, dly_reg[g], seq_reg,
				tick_stb_reg);
		end
	endgenerate

	assign tx_done_w = seq_reg && tick_reg == SEQ_END_TICK;
	wire ramp_on = host_mode_reg[MODE_RAMP_EN_BIT] && ramp_reg != RAMP_IDLE;
	wire ramp_step = tick_stb_reg && ramp_div_reg == dly_reg[7];

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dly_reg       <= {RST_RATE, {7{RST_DELAY}}};
			ramp_val_reg  <= '0;
			mod_level_a_o <= 8'h00;
			mod_level_b_o <= 8'h00;
			arm_reg       <= 1'b0;
			seq_reg       <= 1'b0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (cfg_seq)
					dly_reg[2*i +: 2] <= wd_reg[i];
				if (cfg_ramp)
					ramp_val_reg[i] <= wd_reg[i][9:0];
			end
			if (cfg_lvl) begin
				mod_level_a_o <= wd_reg[0][7:0];
				mod_level_b_o <= wd_reg[1][7:0];
			end
			if (burst_go)
				arm_reg <= 1'b1;
			if (!in_norm) begin
				arm_reg <= 1'b0;
				seq_reg <= 1'b0;
			end else if (slot_edge && arm_reg) begin
				arm_reg <= 1'b0;
				seq_reg <= 1'b1;
			end else if (tx_done_w) begin
				seq_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mod_active_o               <= 1'b0;
			tx_enable_o                <= 1'b0;
			carrier_sense_slot_check_o <= 1'b0;
		end else begin
			// modulation only while a burst runs in normal
			mod_active_o <= in_norm && seq_reg && !hit[1] &&
				(mod_active_o || hit[0]);
			tx_enable_o <= in_norm && seq_reg && !hit[5] &&
				(tx_enable_o || hit[4]);
			carrier_sense_slot_check_o <= hit[6];
		end
	end

	// ramp walks the value series at the set rate
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ramp_reg     <= RAMP_IDLE;
			ramp_idx_reg <= 2'h0;
			ramp_div_reg <= 8'h00;
		end else begin
			if (tick_stb_reg)
				ramp_div_reg <= ramp_step ? 8'h00 : ramp_div_reg + 8'h01;
			case (ramp_reg)
				RAMP_IDLE: begin
					ramp_idx_reg <= 2'h0;
					if (hit[2])
						ramp_reg <= RAMP_UP;
				end
				RAMP_UP: begin
					if (hit[3])
						ramp_reg <= RAMP_DOWN;
					else if (ramp_step && ramp_idx_reg == 2'h3)
						ramp_reg <= RAMP_HOLD;
					else if (ramp_step)
						ramp_idx_reg <= ramp_idx_reg + 2'h1;
				end
				RAMP_HOLD: begin
					if (hit[3])
						ramp_reg <= RAMP_DOWN;
				end
				RAMP_DOWN: begin
					if (ramp_step && ramp_idx_reg == 2'h0)
						ramp_reg <= RAMP_IDLE;
					else if (ramp_step)
						ramp_idx_reg <= ramp_idx_reg - 2'h1;
				end
				default: ramp_reg <= RAMP_IDLE;
			endcase
			if (!seq_reg && !hit[2])
				ramp_reg <= RAMP_IDLE;
		end
	end

	// --------------------------------------------------------------
	// aux output converters
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dac_reg <= '0;
		end else if (dac_go) begin
			// each flagged word updates its converter
			for (int i = 0; i < 4; i++)
				if (wd_reg[i][DAC_WR_VALID_BIT])
					dac_reg[wd_reg[i][DAC_WR_IDX_LSB +: 2]] <=
						wd_reg[i][9:0];
		end
	end

	generate
		for (g = 0; g < 4; g++) begin : g_dac
			always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
				if (!rst_n_i)
					aux_dac_o[g] <= 10'h000;
				else if (g == 0 && ramp_on)
					aux_dac_o[g] <= ramp_val_reg[ramp_idx_reg];
				else
					aux_dac_o[g] <= dac_reg[g];
			end
		end
	endgenerate

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_act_to_sleep: assert property (
		mode_reg == MODE_WAIT_ACT && activation_done_i
		|=> mode_reg == MODE_SLEEP ##1 deep_sleep_o)
		else $error("activation did not reach sleep");
	chk_leave_sleep: assert property (
		modem_go && mode_reg == MODE_SLEEP &&
		modem_code_reg == CT_LEAVE_SLEEP |=> mode_reg == MODE_NORMAL)
		else $error("leave sleep not taken");
	chk_sleep_path: assert property (
		mode_reg == MODE_NORMAL |=> mode_reg != MODE_SLEEP)
		else $error("normal went straight to sleep");
	chk_cfg_mod_off: assert property (
		mode_reg == MODE_CONFIG |-> ##1 !mod_active_o)
		else $error("modulation active in config");
	chk_cfg_enter: assert property (
		modem_go && in_norm && modem_code_reg == MT_ENTER_CFG
		|=> mode_reg == MODE_CONFIG)
		else $error("enter config ignored");
	chk_invalid_hold: assert property (
		modem_go && in_norm && modem_code_reg == CT_TX_SEQUENCE
		|=> $stable(dly_reg) && mode_reg == MODE_NORMAL)
		else $error("invalid task changed state");
	chk_data_first: assert property (
		$rose(data_pend_reg) && modem_pend_reg
		|-> !modem_go ##1 modem_go)
		else $error("modem task overtook data task");
	chk_tick_zero: assert property (
		slot_edge |=> tick_reg == 9'h000 && tick_stb_reg)
		else $error("tick count not restarted");
	chk_irq_out: assert property (
		status_reg[ST_IRQ_BIT] && mask_reg[MASK_IRQ_BIT]
		|=> interrupt_out_n_oe_o)
		else $error("interrupt not asserted");
	chk_sleep_bit: assert property (
		$rose(deep_sleep_o) |-> second_status_word_w[ST2_SLEEP_BIT])
		else $error("sleep indicator missing");

endmodule : atm_task_mode_ctrl

// >>> pkg/atm_pkg.sv
// shared constants for the task and mode controller
// assumes one 250 MHz reference clock and a serial register port
package atm_pkg;

	// --------------------------------------------------------------
	// register addresses
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE    = 8'hC1;
	localparam logic [7:0] ADDR_STATUS  = 8'hC6;
	localparam logic [7:0] ADDR_SECOND_STATUS_WORD = 8'hC7;
	localparam logic [7:0] ADDR_CMD     = 8'hC8;
	localparam logic [7:0] ADDR_ADC     = 8'hC9;
	localparam logic [7:0] ADDR_MASK    = 8'hCE;
	localparam logic [7:0] ADDR_WD0     = 8'hA7;
	localparam logic [7:0] ADDR_WD1     = 8'hA8;
	localparam logic [7:0] ADDR_WD2     = 8'hB6;
	localparam logic [7:0] ADDR_WD3     = 8'hB7;

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int ST_ACT_BIT       = 0;
	localparam int ST_CFG_DONE_BIT  = 1;
	localparam int ST_DATA_DONE_BIT = 2;
	localparam int ST_TX_DONE_BIT   = 3;
	localparam int ST_IRQ_BIT       = 15;
	localparam int ST2_SLEEP_BIT    = 13;
	localparam int MASK_IRQ_BIT     = 15;
	localparam int MODE_ADC_SEL_BIT = 0;
	localparam int MODE_RAMP_EN_BIT = 8;
	localparam int ADC_SEL_BIT      = 12;
	localparam int CMD_MODEM_LSB    = 0;
	localparam int CMD_DATA_LSB     = 4;
	localparam int DAC_WR_VALID_BIT = 15;
	localparam int DAC_WR_IDX_LSB   = 10;

	// --------------------------------------------------------------
	// reset values and timing
	// --------------------------------------------------------------
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [7:0]  RST_DELAY = 8'h00;
	localparam logic [7:0]  RST_RATE  = 8'h01;
	localparam int unsigned CLK_HZ      = 250_000_000;
	localparam int unsigned TICK_HZ     = 24_000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
	localparam logic [8:0]  SEQ_END_TICK = 9'h100;
	localparam logic [4:0]  SER_ADDR_LAST = 5'h07;
	localparam logic [4:0]  SER_WORD_LAST = 5'h17;

	// --------------------------------------------------------------
	// modes and task codes
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_WAIT_ACT = 2'b00,
		MODE_SLEEP    = 2'b01,
		MODE_CONFIG   = 2'b10,
		MODE_NORMAL   = 2'b11
	} atm_mode_e;

	// modem field codes in normal mode
	localparam logic [3:0] MT_TX_BURST      = 4'h1;
	localparam logic [3:0] MT_TX_DATA_BURST = 4'h2;
	localparam logic [3:0] MT_ENTER_CFG     = 4'h3;
	// same field carries configuration tasks outside normal mode
	localparam logic [3:0] CT_EXIT_CFG      = 4'h1;
	localparam logic [3:0] CT_ENTER_SLEEP   = 4'h2;
	localparam logic [3:0] CT_LEAVE_SLEEP   = 4'h3;
	localparam logic [3:0] CT_TX_SEQUENCE   = 4'h4;
	localparam logic [3:0] CT_MOD_LEVEL     = 4'h5;
	localparam logic [3:0] CT_RAMP_VALUES   = 4'h6;
	localparam logic [3:0] DT_DAC_WRITE     = 4'h1;

	typedef enum logic [1:0] {
		RAMP_IDLE = 2'b00,
		RAMP_UP   = 2'b01,
		RAMP_HOLD = 2'b10,
		RAMP_DOWN = 2'b11
	} atm_ramp_e;

	function automatic logic atm_is_read(input logic [7:0] a);
		atm_is_read = (a == ADDR_STATUS) || (a == ADDR_SECOND_STATUS_WORD) ||
			(a == ADDR_ADC);
	endfunction : atm_is_read

endpackage : atm_pkg

// >>> rtl/atm_serial_port.sv
// serial register port: address byte then one 16-bit word, msb first
// assumes the port pins are asynchronous to ref_clk_i and slow
module atm_serial_port
	import atm_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ser_sel_n_i,
	input  wire logic        ser_clk_i,
	input  wire logic        ser_din_i,
	input  wire logic [15:0] rd_data_i,
	output logic             ser_dout_o,
	output logic             ser_dout_oe_o,
	output logic             wr_stb_o,
	output logic             rd_stb_o,
	output logic [7:0]       addr_o,
	output logic [15:0]      wr_data_o
);
	logic [1:0]  sel_s_reg;
	logic [2:0]  clk_s_reg;
	logic [1:0]  din_s_reg;
	logic [4:0]  cnt_reg;
	logic [15:0] in_sh_reg;
	logic [15:0] out_sh_reg;
	logic        rd_reg;
	logic        load_reg;

	wire rise_w = clk_s_reg[1] & ~clk_s_reg[2];
	wire fall_w = ~clk_s_reg[1] & clk_s_reg[2];
	wire [15:0] shifted_w = {in_sh_reg[14:0], din_s_reg[1]};

	assign ser_dout_o = out_sh_reg[15];

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_s_reg <= 2'h3;
			clk_s_reg <= 3'h0;
			din_s_reg <= 2'h0;
		end else begin
			sel_s_reg <= {sel_s_reg[0], ser_sel_n_i};
			clk_s_reg <= {clk_s_reg[1:0], ser_clk_i};
			din_s_reg <= {din_s_reg[0], ser_din_i};
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg       <= 5'h00;
			in_sh_reg     <= 16'h0000;
			out_sh_reg    <= 16'h0000;
			rd_reg        <= 1'b0;
			load_reg      <= 1'b0;
			ser_dout_oe_o <= 1'b0;
			wr_stb_o      <= 1'b0;
			rd_stb_o      <= 1'b0;
			addr_o        <= 8'h00;
			wr_data_o     <= 16'h0000;
		end else begin
			wr_stb_o <= 1'b0;
			rd_stb_o <= 1'b0;
			load_reg <= 1'b0;
			if (load_reg)
				out_sh_reg <= rd_data_i;
			if (sel_s_reg[1]) begin
				cnt_reg       <= 5'h00;
				rd_reg        <= 1'b0;
				ser_dout_oe_o <= 1'b0;
			end else if (rise_w && cnt_reg <= SER_WORD_LAST) begin
				in_sh_reg <= shifted_w;
				cnt_reg   <= cnt_reg + 5'h01;
				if (cnt_reg == SER_ADDR_LAST) begin
					addr_o <= shifted_w[7:0];
					if (atm_is_read(shifted_w[7:0])) begin
						rd_reg        <= 1'b1;
						load_reg      <= 1'b1;
						ser_dout_oe_o <= 1'b1;
					end
				end
				// whole word lands in one strobe, never a half
				if (cnt_reg == SER_WORD_LAST) begin
					wr_stb_o  <= ~rd_reg;
					rd_stb_o  <= rd_reg;
					wr_data_o <= shifted_w;
				end
			end else if (fall_w && rd_reg && cnt_reg > 5'h08) begin
				// next bit must be stable while the clock is high
				out_sh_reg <= {out_sh_reg[14:0], 1'b0};
			end
		end
	end

endmodule : atm_serial_port

// >>> test/atm_host_model.sv
// host model: serial register port master and slot pulse source
// assumes ref_clk_i is the device clock; link bit time is 64 ns
module atm_host_model
	import atm_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic ser_dout_i,
	output logic      ser_sel_n_o,
	output logic      ser_clk_o,
	output logic      ser_din_o,
	output logic      slot_pulse_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ser_sel_n_o = 1'b1;
		ser_clk_o = 1'b0;
		ser_din_o = 1'b0;
		slot_pulse_o = 1'b0;
	end
	// ------------------------------------------------------------
	// one frame: address then word, msb first
	// ------------------------------------------------------------
	task automatic xfer(input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		logic [23:0] w;
		w = {a, d};
		q = 16'h0000;
		@(posedge ref_clk_i) ser_sel_n_o <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		for (int i = 23; i >= 0; i--) begin
			ser_din_o <= w[i];
			repeat (8) @(posedge ref_clk_i);
			ser_clk_o <= 1'b1;
			repeat (8) @(posedge ref_clk_i);
			if (i < 16) q[i] = ser_dout_i;
			ser_clk_o <= 1'b0;
		end
		repeat (8) @(posedge ref_clk_i);
		// released line shows the inverse, never a held level
		ser_din_o <= ~w[0];
		ser_sel_n_o <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
	endtask : xfer
	task automatic slot();
		@(posedge ref_clk_i) slot_pulse_o <= 1'b1;
		repeat (13000) @(posedge ref_clk_i);
		slot_pulse_o <= 1'b0;
	endtask : slot
endmodule : atm_host_model

// >>> test/ais_task_mode_controller_tb.sv
// testbench: mode walk, command decode, burst timing, irq, converter
// assumes the host model drives the port pins and the slot pulse
module ais_task_mode_controller_tb
	import atm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 16;
	logic ref_clk_i, rst_n_i, ser_sel_n_i, ser_clk_i, ser_din_i;
	logic activation_done_i, slot_timing_pulse_i, aux_adc_valid_i;
	logic [9:0] aux_converter_in_i;
	logic ser_dout_o, ser_dout_oe_o, slot_pulse_echo_o, deep_sleep_o;
	logic interrupt_out_n_o, interrupt_out_n_oe_o, mod_active_o;
	logic tx_enable_o, carrier_sense_slot_check_o, aux_adc_sel_o;
	logic [7:0] mod_level_a_o, mod_level_b_o;
	logic [3:0][9:0] aux_dac_o;
	logic [15:0] q;
	longint t[5];
	int ex[5] = '{0, 1, 3, 7, 8};
	int num_errors = 0;
	int compares = 0;
	atm_task_mode_ctrl #(.TICK_CYC(TK)) atm_task_mode_ctrl_i (
		.ref_clk_i, .rst_n_i, .ser_sel_n_i, .ser_clk_i, .ser_din_i,
		.activation_done_i, .slot_timing_pulse_i, .aux_converter_in_i,
		.aux_adc_valid_i, .ser_dout_o, .ser_dout_oe_o, .slot_pulse_echo_o,
		.interrupt_out_n_o, .interrupt_out_n_oe_o, .mod_active_o,
		.mod_level_a_o, .mod_level_b_o, .tx_enable_o,
		.carrier_sense_slot_check_o, .aux_adc_sel_o, .aux_dac_o,
		.deep_sleep_o);
	atm_host_model atm_host_model_i (.ref_clk_i, .ser_dout_i(ser_dout_o),
		.ser_sel_n_o(ser_sel_n_i), .ser_clk_o(ser_clk_i),
		.ser_din_o(ser_din_i), .slot_pulse_o(slot_timing_pulse_i));
	// ------------------------------------------------------------
	// access and compare tasks
	// ------------------------------------------------------------
	task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %0t word %h exp %h", $time, g, e);
		end
	endtask : chk_w
	task automatic chk_b(input logic g, input logic e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %0t flag %b exp %b", $time, g, e);
		end
	endtask : chk_b
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] r;
		atm_host_model_i.xfer(a, d, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] r);
		atm_host_model_i.xfer(a, 16'hFFFF, r);
	endtask : rd
	task automatic cmd(input logic [3:0] d, input logic [3:0] m);
		wr(ADDR_CMD, {8'h00, d, m});
	endtask : cmd
	task automatic wd4(input logic [15:0] a, b, c, d);
		wr(ADDR_WD0, a);
		wr(ADDR_WD1, b);
		wr(ADDR_WD2, c);
		wr(ADDR_WD3, d);
	endtask : wd4
	task automatic st2(input logic [15:0] e);
		logic [15:0] r;
		rd(ADDR_SECOND_STATUS_WORD, r);
		chk_w(r & 16'h2003, e);
	endtask : st2
	task automatic give_verdict();
		if (num_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	// ------------------------------------------------------------
	// clock, watchdog, tests
	// ------------------------------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		repeat (80000) @(posedge ref_clk_i);
		num_errors++;
		give_verdict();
	end
	initial begin
		rst_n_i = 1'b0;
		activation_done_i = 1'b0;
		aux_adc_valid_i = 1'b0;
		aux_converter_in_i = 10'h000;
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		st2(16'h0000);
		activation_done_i <= 1'b1;
		@(posedge ref_clk_i) activation_done_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		chk_b(deep_sleep_o, 1'b1);
		st2(16'h2001);
		// analogue taken as powered up here
		cmd(4'h0, CT_LEAVE_SLEEP);
		st2(16'h0003);
		cmd(4'h0, 4'h4);
		st2(16'h0003);
		cmd(4'h0, MT_ENTER_CFG);
		st2(16'h0002);
		cmd(4'h0, CT_LEAVE_SLEEP);
		st2(16'h0002);
		chk_b(mod_active_o, 1'b0);
		wd4(16'h0A02, 16'h0C01, 16'h0903, 16'h0105);
		cmd(4'h0, CT_TX_SEQUENCE);
		wd4(16'h002A, 16'h0015, 16'h0133, 16'h0255);
		cmd(4'h0, CT_MOD_LEVEL);
		cmd(4'h0, CT_RAMP_VALUES);
		chk_w({8'h00, mod_level_a_o}, 16'h002A);
		chk_w({8'h00, mod_level_b_o}, 16'h0015);
		cmd(4'h0, CT_EXIT_CFG);
		st2(16'h0003);
		wr(ADDR_MODE, 16'h0100);
		wd4(16'h8555, 16'h0BFF, 16'h8EAA, 16'h0000);
		cmd(DT_DAC_WRITE, MT_TX_BURST);
		chk_w({6'h00, aux_dac_o[1]}, 16'h0155);
		chk_w({6'h00, aux_dac_o[3]}, 16'h02AA);
		chk_w({6'h00, aux_dac_o[2]}, 16'h0000);
		fork
			atm_host_model_i.slot();
			begin
				@(posedge mod_active_o) t[0] = $time;
				@(posedge tx_enable_o) t[1] = $time;
				@(posedge carrier_sense_slot_check_o) t[2] = $time;
				@(negedge tx_enable_o) t[3] = $time;
				@(negedge mod_active_o) t[4] = $time;
				chk_b(slot_pulse_echo_o, 1'b1);
				// ramp has walked up to its last value
				chk_w({6'h00, aux_dac_o[0]}, 16'h0255);
			end
		join
		// spacing only: sync latency is common to every event
		for (int i = 1; i < 5; i++)
			chk_w(16'((t[i] - t[0]) / 4), 16'(ex[i] * TK));
		cmd(4'h0, MT_TX_DATA_BURST);
		fork
			atm_host_model_i.slot();
			begin
				@(posedge tx_enable_o) t[0] = $time;
				@(negedge tx_enable_o) t[1] = $time;
			end
		join
		chk_w(16'((t[1] - t[0]) / 4), 16'(6 * TK));
		chk_b(interrupt_out_n_oe_o, 1'b0);
		wr(ADDR_MASK, 16'h8000);
		chk_b(interrupt_out_n_oe_o, 1'b1);
		chk_b(interrupt_out_n_o, 1'b0);
		rd(ADDR_STATUS, q);
		chk_w(q & 16'h8009, 16'h8009);
		repeat (2) @(posedge ref_clk_i);
		chk_b(interrupt_out_n_oe_o, 1'b0);
		wr(ADDR_MODE, 16'h0001);
		aux_converter_in_i <= 10'h2C3;
		aux_adc_valid_i <= 1'b1;
		@(posedge ref_clk_i) aux_adc_valid_i <= 1'b0;
		fork
			rd(ADDR_ADC, q);
			@(posedge ser_dout_oe_o) chk_b(ser_sel_n_i, 1'b0);
		join
		chk_w(q, 16'h12C3);
		chk_b(ser_dout_oe_o, 1'b0);
		cmd(4'h0, MT_ENTER_CFG);
		cmd(4'h0, CT_ENTER_SLEEP);
		chk_b(deep_sleep_o, 1'b1);
		st2(16'h2001);
		give_verdict();
	end
endmodule : ais_task_mode_controller_tb
